// [include/tam_pkg.sv]
// constants and types shared by the touch measurement sequencer
package tam_pkg;
  // ==========================================
  // clocking and conversion timing
  localparam int PCLK_HZ = 40_000_000;
  localparam int CCLK8_HZ = 4_000_000;
  localparam int CCLK12_HZ = 2_000_000;
  localparam int DIV8 = PCLK_HZ / CCLK8_HZ;
  localparam int DIV12 = PCLK_HZ / CCLK12_HZ;
  localparam int STEP12_CLKS = 19;
  localparam int STEP8_CLKS = 16;
  localparam int FILT_STEPS = 7;
  localparam int FILTER_CLKS = 19;
  localparam int OVERLAP_CLKS = 4;
  localparam int CMD_BITS = 8;
  localparam int CMD_START_POS = 7;
  localparam int CMD_RES8_POS = 3;
  localparam int FRAME_A = 8;
  localparam int FRAME_B = 16;
  localparam int FRAME_C = 24;
  // reciprocal of seven, scaled by two to the sixteenth
  localparam int RECIP7 = 9363;
  localparam int RECIP_SHIFT = 16;
  // ==========================================
  // register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] RESULT_OFS = 12'h008;
  localparam logic [11:0] COUNT_OFS = 12'h00C;
  localparam int CTRL_FILT_POS = 0;
  localparam int CTRL_EARLY_POS = 1;
  localparam int CTRL_FRAME_POS = 2;
  localparam logic [3:0] CTRL_RST = 4'h5;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_RES8_POS = 1;
  localparam int ST_OVR_POS = 2;
  localparam int ST_LEVEL_POS = 8;
  typedef enum logic [1:0] {TAM_IDLE, TAM_CONV, TAM_FILT, TAM_PUSH} tam_state_t;
endpackage

// [rtl/tam_sequencer.sv]
// touch measurement sequencer with apb registers, spi slave and result fifo
//
// The APB register port and the address map are this design's own decisions.

// ==========================================
// result fifo
module tam_fifo
  import tam_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
)
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic in_valid, // push request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // pushed word
  output logic out_valid, // word available
  input wire logic out_ready, // pop request
  output logic [WIDTH-1:0] out_data, // head word
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // honest flags from the word count
  assign in_ready = cnt_reg != DEPTH[AW:0];
  assign out_valid = cnt_reg != '0;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;
  assign out_data = mem_reg[rd_reg];
  assign level = cnt_reg;

  // storage writes, no reset needed on data
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ==========================================
// top level
module tam_sequencer
#(
  parameter int FIFO_DEPTH = 32
)
(
  input wire logic pclk, // bus clock, 40 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic cs_n, // spi select, low
  input wire logic sclk, // spi clock from host
  input wire logic mosi, // spi data in
  output logic miso, // spi data out
  output logic miso_oe, // drive enable for miso
  output logic adc_start, // pulse: begin acquisition
  output logic adc_res8, // converter in 8-bit mode
  input wire logic [11:0] adc_data // converted sample
);
  import tam_pkg::*;

  tam_state_t state_reg;
  logic [3:0] ctrl_reg;
  logic ovr_reg;
  logic [11:0] last_reg;
  logic [31:0] count_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic sclk_q_reg;
  logic [4:0] bit_reg;
  logic idle_reg;
  logic [6:0] cmd_reg;
  logic [11:0] tx_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic [4:0] div_reg;
  logic [4:0] cyc_reg;
  logic [2:0] step_reg;
  logic [14:0] sum_reg;
  logic res8_reg;
  logic filt_reg;
  logic adc_start_reg;
  logic rise;
  logic fall;
  logic cmd_done;
  logic [7:0] cmd_full;
  logic start;
  logic tick;
  logic tx_load;
  logic tx_pop;
  logic loaded_reg;
  logic apb_wr;
  logic apb_acc;
  logic [28:0] product;
  logic [11:0] result;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [11:0] fifo_out_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  // frame length chosen by software
  function automatic logic [4:0] frame_clocks(input logic [1:0] sel);
    unique case (sel)
      2'h0: frame_clocks = 5'(FRAME_A);
      2'h1: frame_clocks = 5'(FRAME_B);
      default: frame_clocks = 5'(FRAME_C);
    endcase
  endfunction

  // conversion clocks in one step, first step shortened by the overlap
  function automatic logic [4:0] step_clocks(input logic r8, input logic first);
    logic [4:0] n;
    n = r8 ? 5'(STEP8_CLKS) : 5'(STEP12_CLKS);
    step_clocks = first ? n - 5'(OVERLAP_CLKS) : n;
  endfunction

  // ==========================================
  // apb slave
  assign apb_acc = psel && penable && !pready_reg;
  assign apb_wr = psel && penable && pready_reg && pwrite;

  // one wait state keeps every bus output registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end
    else
    begin
      pready_reg <= apb_acc;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      if (apb_acc)
      begin
        unique case (paddr)
          CTRL_OFS: prdata_reg <= {28'h0000000, ctrl_reg};
          STATUS_OFS:
          begin
            prdata_reg[ST_BUSY_POS] <= state_reg != TAM_IDLE;
            prdata_reg[ST_RES8_POS] <= res8_reg;
            prdata_reg[ST_OVR_POS] <= ovr_reg;
            prdata_reg[ST_LEVEL_POS +: $bits(fifo_level)] <= fifo_level;
          end
          RESULT_OFS: prdata_reg <= {20'h00000, last_reg};
          COUNT_OFS: prdata_reg <= count_reg;
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RST;
    end
    else if (apb_wr && paddr == CTRL_OFS)
    begin
      ctrl_reg <= pwdata[3:0];
    end
  end

  // overrun flag, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_reg <= 1'b0;
    end
    else if (cmd_done && !start)
    begin
      ovr_reg <= 1'b1;
    end
    else if (apb_wr && paddr == STATUS_OFS && pwdata[ST_OVR_POS])
    begin
      ovr_reg <= 1'b0;
    end
  end

  // ==========================================
  // spi slave, pins taken as synchronous to pclk
  assign rise = sclk && !sclk_q_reg && !cs_n;
  assign fall = !sclk && sclk_q_reg && !cs_n;
  assign cmd_full = {cmd_reg, mosi};
  assign cmd_done = rise && !idle_reg && bit_reg == 5'(CMD_BITS - 1);
  assign tx_load = (rise && idle_reg) || (!cs_n && !miso_oe_reg);
  // the head word leaves the fifo at the first sclk rise of a frame, so a deselect before that loses nothing
  assign tx_pop = rise && miso_oe_reg && !idle_reg && bit_reg == '0 && loaded_reg;
  // a command is honoured only when the sequencer and fifo can take it
  assign start = cmd_done && cmd_full[CMD_START_POS] && state_reg == TAM_IDLE && fifo_in_ready;

  // bit counter; after each frame one clock is spent idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_q_reg <= 1'b0;
      bit_reg <= '0;
      idle_reg <= 1'b0;
      cmd_reg <= '0;
    end
    else
    begin
      sclk_q_reg <= sclk;
      if (cs_n)
      begin
        bit_reg <= '0;
        idle_reg <= 1'b0;
      end
      else if (rise && idle_reg)
      begin
        idle_reg <= 1'b0;
      end
      else if (rise)
      begin
        cmd_reg <= cmd_full[6:0];
        if (bit_reg == frame_clocks(ctrl_reg[CTRL_FRAME_POS +: 2]) - 5'd1)
        begin
          bit_reg <= '0;
          idle_reg <= 1'b1;
        end
        else
        begin
          bit_reg <= bit_reg + 5'd1;
        end
      end
    end
  end

  // output shifter, loaded only between frames so a result never changes mid-frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_reg <= '0;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end
    else
    begin
      miso_oe_reg <= !cs_n;
      // shifter holds a peeked fifo word until the frame starts
      if (tx_load)
      begin
        loaded_reg <= fifo_out_valid;
      end
      else if (tx_pop)
      begin
        loaded_reg <= 1'b0;
      end
      if (tx_load)
      begin
        // early release shows the msb at once; legacy leads with one null bit
        if (ctrl_reg[CTRL_EARLY_POS])
        begin
          miso_reg <= fifo_out_valid && fifo_out_data[11];
          tx_reg <= fifo_out_valid ? {fifo_out_data[10:0], 1'b0} : '0;
        end
        else
        begin
          miso_reg <= 1'b0;
          tx_reg <= fifo_out_valid ? fifo_out_data : '0;
        end
      end
      else if (fall && !idle_reg && bit_reg != '0)
      begin
        miso_reg <= tx_reg[11];
        tx_reg <= {tx_reg[10:0], 1'b0};
      end
    end
  end

  // ==========================================
  // conversion clock from the pclk divider
  assign tick = div_reg == (res8_reg ? 5'(DIV8 - 1) : 5'(DIV12 - 1));

  // divider runs free so later steps ignore sclk entirely
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= tick ? '0 : div_reg + 5'd1;
    end
  end

  // ==========================================
  // measurement sequence
  assign product = 29'(sum_reg * 15'(RECIP7));
  assign result = filt_reg ? product[RECIP_SHIFT +: 12] : sum_reg[11:0];

  // steps, filter loop and push into the fifo; host may leave meanwhile
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= TAM_IDLE;
      cyc_reg <= '0;
      step_reg <= '0;
      sum_reg <= '0;
      res8_reg <= 1'b0;
      filt_reg <= 1'b0;
      adc_start_reg <= 1'b0;
      last_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      adc_start_reg <= 1'b0;
      unique case (state_reg)
        TAM_IDLE:
        begin
          if (start)
          begin
            state_reg <= TAM_CONV;
            res8_reg <= cmd_full[CMD_RES8_POS];
            filt_reg <= ctrl_reg[CTRL_FILT_POS];
            cyc_reg <= '0;
            step_reg <= '0;
            sum_reg <= '0;
            adc_start_reg <= 1'b1;
          end
        end
        TAM_CONV:
        begin
          if (tick && cyc_reg == step_clocks(res8_reg, step_reg == '0) - 5'd1)
          begin
            sum_reg <= sum_reg + {3'b000, adc_data};
            cyc_reg <= '0;
            if (!filt_reg || step_reg == 3'(FILT_STEPS - 1))
            begin
              state_reg <= filt_reg ? TAM_FILT : TAM_PUSH;
            end
            else
            begin
              step_reg <= step_reg + 3'd1;
              adc_start_reg <= 1'b1;
            end
          end
          else if (tick)
          begin
            cyc_reg <= cyc_reg + 5'd1;
          end
        end
        TAM_FILT:
        begin
          if (tick && cyc_reg == 5'(FILTER_CLKS - 1))
          begin
            state_reg <= TAM_PUSH;
          end
          else if (tick)
          begin
            cyc_reg <= cyc_reg + 5'd1;
          end
        end
        TAM_PUSH:
        begin
          // waits here while the fifo is full
          if (fifo_in_ready)
          begin
            state_reg <= TAM_IDLE;
            last_reg <= result;
            count_reg <= count_reg + 32'd1;
          end
        end
      endcase
    end
  end

  // result queue between sequencer and spi readout
  tam_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(state_reg == TAM_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(result),
    .out_valid(fifo_out_valid),
    .out_ready(tx_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ==========================================
  // outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign miso = miso_reg;
  assign miso_oe = miso_oe_reg;
  assign adc_start = adc_start_reg;
  assign adc_res8 = res8_reg;
endmodule

// [verif/tam_sequencer_monitor.sv]
// port checker for the touch measurement sequencer
module tam_sequencer_monitor
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic cs_n, // spi select
  input wire logic sclk, // spi clock
  input wire logic miso, // spi out
  input wire logic miso_oe, // out enable
  input wire logic adc_start, // step start
  input wire logic adc_res8 // 8-bit mode
);
  // ==========================================
  // step gap counter
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] gap_reg;
  // cycles since the last step start; saturates so idle gaps drop out
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      gap_reg <= 10'h3FF;
    else if (adc_start)
      gap_reg <= 10'h000;
    else if (gap_reg != 10'h3FF)
      gap_reg <= gap_reg + 10'h001;
  // ==========================================
  // assertions
  a_pready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_one_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("pready not in second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_oe_tracks: assert property (1'b1 |=> miso_oe == !$past(cs_n))
    else $error("miso_oe not following select");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("adc_start longer than one cycle");
  a_step_gap: assert property (adc_start && gap_reg < 10'd400 |->
    (adc_res8 ? gap_reg inside {[109:159]} : gap_reg inside {[279:379]}))
    else $error("step spacing off");
  a_miso_holds: assert property ((!cs_n && sclk)[*5] |-> $stable(miso))
    else $error("miso moved while sclk high");
endmodule

bind tam_sequencer tam_sequencer_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .cs_n, .sclk, .miso, .miso_oe, .adc_start, .adc_res8);

// [verif/tam_spi_host.sv]
// spi host model that frames commands and reads results
module tam_spi_host
(
  input wire logic pclk, // bus clock
  output logic cs_n, // select, low
  output logic sclk, // serial clock
  output logic mosi, // serial data out
  input wire logic miso // serial data in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // frame driver
  localparam int HALF = 8; // pclk per sclk half, slower than pclk/4
  // idle bus: select high, clock parked low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // n data clocks, one idle clock, then release the bus for others
  task automatic frame(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    cs_n <= 1'b0;
    for (int i = 0; i <= n; i++)
    begin
      mosi <= (i < n) ? tx[n - 1 - i] : ~mosi;
      repeat (HALF) @(posedge pclk);
      if (i < n)
        rx = {rx[22:0], miso};
      sclk <= 1'b1;
      repeat (HALF) @(posedge pclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge pclk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    @(posedge pclk);
  endtask
endmodule

// [verif/tam_sequencer_tb.sv]
// self-checking testbench for the touch measurement sequencer
module tam_sequencer_tb
  import tam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] adc_data = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic [23:0] rx;
  logic pready, pslverr, err, cs_n, sclk, mosi, miso, miso_oe, adc_start, adc_res8;
  int failures = 0;
  int checks = 0;
  int starts = 0;
  int cycles = 0;
  // ==========================================
  // design, far side and clock
  tam_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
    .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .adc_start(adc_start),
    .adc_res8(adc_res8), .adc_data(adc_data));
  tam_spi_host u_host (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  initial forever #12.5 pclk = ~pclk;
  // count step starts; a hang ends the run
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (adc_start === 1'b1)
      starts <= starts + 1;
    if (cycles == 20000)
    begin
      failures++;
      finish_test();
    end
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an edge after release keeps transfers apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_level(input int n);
    apb(1'b0, STATUS_OFS, 32'h00000000);
    while (rd[13:8] !== 6'(n))
      apb(1'b0, STATUS_OFS, 32'h00000000);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic test_regs();
    apb(1'b0, CTRL_OFS, 32'h00000000);
    chk(rd, {28'h0000000, CTRL_RST});
    apb(1'b0, STATUS_OFS, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    chk({rd[30:0], err}, 32'h00000001);
    apb(1'b1, RESULT_OFS, 32'h00000FFF);
    apb(1'b0, RESULT_OFS, 32'h00000000);
    chk(rd, 32'h00000000);
    $display("test_regs done");
  endtask
  // unfiltered 12-bit step, read with early timing in a 16-clock frame
  task automatic test_raw();
    int s0;
    int t0;
    apb(1'b1, CTRL_OFS, 32'h00000006);
    s0 = starts;
    t0 = cycles;
    adc_data <= 12'h5A3;
    u_host.frame(16, 24'h008000, rx);
    wait_level(1);
    chk((cycles - t0) inside {[390:450]}, 1);
    chk(starts - s0, 1);
    u_host.frame(16, 24'h000000, rx);
    chk(rx[15:4], 12'h5A3);
    $display("test_raw done");
  endtask
  // filtered 12-bit, then 8-bit started in the overlapping readout frame
  task automatic test_measure();
    int s0;
    int t0;
    s0 = starts;
    t0 = cycles;
    adc_data <= 12'hA5C;
    apb(1'b1, CTRL_OFS, 32'h00000005);
    u_host.frame(16, 24'h008000, rx);
    wait_level(1);
    chk((cycles - t0) inside {[3050:3120]}, 1);
    chk(starts - s0, 7);
    apb(1'b0, RESULT_OFS, 32'h00000000);
    chk(rd, (7 * 32'h00000A5C * RECIP7) >> RECIP_SHIFT);
    apb(1'b1, CTRL_OFS, 32'h00000009);
    s0 = starts;
    t0 = cycles;
    adc_data <= 12'h3C0;
    u_host.frame(24, 24'h880000, rx);
    chk(rx[23:11], 13'h0A5C);
    apb(1'b0, STATUS_OFS, 32'h00000000);
    chk(rd[ST_BUSY_POS], 1);
    wait_level(1);
    chk((cycles - t0) inside {[1370:1430]}, 1);
    chk(starts - s0, 7);
    chk(rd[ST_RES8_POS], 1);
    apb(1'b1, CTRL_OFS, 32'h00000003);
    u_host.frame(8, 24'h000000, rx);
    chk(rx[7:0], 8'h3C);
    apb(1'b0, STATUS_OFS, 32'h00000000);
    chk(rd[ST_OVR_POS], 1);
    apb(1'b1, STATUS_OFS, 32'h00000004);
    apb(1'b0, STATUS_OFS, 32'h00000000);
    chk(rd, 32'h00000002);
    apb(1'b0, COUNT_OFS, 32'h00000000);
    chk(rd, 32'h00000003);
    $display("test_measure done");
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_raw();
    test_measure();
    finish_test();
  end
endmodule
